// >>> plw_regs.vh
// constants for the position limit and wrap manager
`ifndef PLW_REGS_VH
`define PLW_REGS_VH
`define PLW_POS_W 24
`define PLW_ROT_W 16
`define PLW_GEAR_W 16
// move type codes
`define PLW_MT_POSITION 2'h0
`define PLW_MT_CONTINUOUS 2'h1
`define PLW_MT_TEST 2'h2
`define PLW_MT_HOMING 2'h3
// stop action codes
`define PLW_OT_IMMEDIATE 1'h0
`define PLW_OT_DECEL 1'h1
// reset values of the settings
`define PLW_SOFT_OT_RST 1'h1
`define PLW_OT_ACTION_RST 1'h0
`define PLW_POS_LIMIT_RST 24'h7FFFFF
`define PLW_NEG_LIMIT_RST 24'h800000
`define PLW_HOME_ALM_RST 1'h0
`define PLW_WRAP_EN_RST 1'h0
`define PLW_WRAP_RANGE_RST 24'h0003E8
`define PLW_GEAR_RST 16'h0001
`define PLW_ABS_BACKUP_RST 1'h0
// gear validity multipliers
`define PLW_GEAR_B_MUL 10'h3E8
`define PLW_GEAR_A_MUL 6'h32
`endif

// >>> plw_limit_wrap.v
// position soft limit, origin and wrap supervision
`timescale 1ns/1ps
`include "plw_regs.vh"

module plw_limit_wrap #(
  parameter POS_W = `PLW_POS_W,
  parameter ROT_W = `PLW_ROT_W,
  parameter GEAR_W = `PLW_GEAR_W
) (
  input wire clk,
  input wire nrst,
  input wire cfg_load,
  input wire cfg_soft_ot_enable,
  input wire cfg_ot_action,
  input wire [POS_W-1:0] cfg_pos_limit,
  input wire [POS_W-1:0] cfg_neg_limit,
  input wire cfg_home_alarm_enable,
  input wire cfg_wrap_enable,
  input wire [POS_W-1:0] cfg_wrap_range,
  input wire [GEAR_W-1:0] cfg_gear_a,
  input wire [GEAR_W-1:0] cfg_gear_b,
  input wire cfg_abs_backup_enable,
  input wire power_on_event,
  input wire config_execute,
  input wire homing_done,
  input wire origin_preset_input,
  input wire abs_error_alarm,
  input wire abs_error_clear_input,
  input wire alarm_reset_input,
  input wire start_input,
  input wire sequential_start_input,
  input wire [5:0] direct_select_inputs,
  input wire [1:0] limit_sensor_inputs,
  input wire moving,
  input wire [1:0] move_type,
  input wire step_pulse,
  input wire step_dir,
  output reg [POS_W-1:0] cmd_position,
  output reg [ROT_W-1:0] multi_rot,
  output reg origin_set,
  output reg ot_pos,
  output reg ot_neg,
  output reg permit_pos,
  output reg permit_neg,
  output reg stop_immediate,
  output reg stop_decel,
  output reg [POS_W-1:0] stop_target,
  output reg home_alarm,
  output reg positioning_refused,
  output reg wrap_warning,
  output reg wrap_error_alarm
);

  // ****************************************
  // settings store
  // ****************************************
  reg soft_ot_en;
  reg ot_action;
  reg [POS_W-1:0] pos_limit;
  reg [POS_W-1:0] neg_limit;
  reg home_alarm_en;
  reg wrap_en;
  reg [POS_W-1:0] wrap_range;
  reg [GEAR_W-1:0] gear_a;
  reg [GEAR_W-1:0] gear_b;
  reg abs_backup_en;
  reg limit_change_stop;
  reg abs_err_pending;
  reg start_prev;

  wire limit_rewrite;
  assign limit_rewrite = cfg_load &&
    ((cfg_pos_limit != pos_limit) || (cfg_neg_limit != neg_limit));

  always @(posedge clk) begin
    if (!nrst) begin
      soft_ot_en <= `PLW_SOFT_OT_RST;
      ot_action <= `PLW_OT_ACTION_RST;
      pos_limit <= `PLW_POS_LIMIT_RST;
      neg_limit <= `PLW_NEG_LIMIT_RST;
      home_alarm_en <= `PLW_HOME_ALM_RST;
      wrap_en <= `PLW_WRAP_EN_RST;
      wrap_range <= `PLW_WRAP_RANGE_RST;
      gear_a <= `PLW_GEAR_RST;
      gear_b <= `PLW_GEAR_RST;
      abs_backup_en <= `PLW_ABS_BACKUP_RST;
    end else if (cfg_load) begin
      soft_ot_en <= cfg_soft_ot_enable;
      ot_action <= cfg_ot_action;
      pos_limit <= cfg_pos_limit;
      neg_limit <= cfg_neg_limit;
      home_alarm_en <= cfg_home_alarm_enable;
      wrap_en <= cfg_wrap_enable;
      wrap_range <= cfg_wrap_range;
      gear_a <= cfg_gear_a;
      gear_b <= cfg_gear_b;
      abs_backup_en <= cfg_abs_backup_enable;
    end
  end

  // ****************************************
  // origin tracking
  // ****************************************
  wire set_origin;
  wire lose_origin;
  // origin cannot be re-established while an absolute error is uncleared
  assign set_origin = (homing_done || origin_preset_input) && !abs_err_pending;
  assign lose_origin = (abs_backup_en && abs_error_alarm) ||
    (!abs_backup_en && power_on_event);

  always @(posedge clk) begin
    if (!nrst) begin
      origin_set <= 1'b0;
      abs_err_pending <= 1'b0;
    end else begin
      if (abs_backup_en && abs_error_alarm) begin
        abs_err_pending <= 1'b1;
      end else if (abs_error_clear_input) begin
        abs_err_pending <= 1'b0;
      end
      if (set_origin) begin
        origin_set <= 1'b1;
      end else if (lose_origin) begin
        origin_set <= 1'b0;
      end
    end
  end

  // ****************************************
  // limit checking and escape
  // ****************************************
  wire check_active;
  wire at_pos;
  wire at_neg;
  wire beyond_pos;
  wire beyond_neg;
  wire ls_block;
  wire allow_p;
  wire allow_n;
  wire need_stop;
  wire lim_stop;

  assign check_active = soft_ot_en && origin_set && !wrap_en;
  assign at_pos = $signed(cmd_position) >= $signed(pos_limit);
  assign at_neg = $signed(cmd_position) <= $signed(neg_limit);
  assign beyond_pos = check_active && ($signed(cmd_position) > $signed(pos_limit));
  assign beyond_neg = check_active && ($signed(cmd_position) < $signed(neg_limit));
  // a positioning move stays locked while any sensor is active
  assign ls_block = (move_type == `PLW_MT_POSITION) && (limit_sensor_inputs != 2'h0);
  // outside a positioning move, only the direction into a hit limit is blocked
  assign allow_p = !(check_active && at_pos) && !limit_sensor_inputs[1] && !ls_block;
  assign allow_n = !(check_active && at_neg) && !limit_sensor_inputs[0] && !ls_block;
  assign need_stop = moving && check_active &&
    ((step_dir && at_pos) || (!step_dir && at_neg));
  // a rewrite stops the motor in the cycle it lands, while still moving
  assign lim_stop = moving && (limit_change_stop || limit_rewrite);

  always @(posedge clk) begin
    if (!nrst) begin
      limit_change_stop <= 1'b0;
    end else if (moving && limit_rewrite) begin
      limit_change_stop <= 1'b1;
    end else if (!moving) begin
      limit_change_stop <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (!nrst) begin
      ot_pos <= 1'b0;
      ot_neg <= 1'b0;
      permit_pos <= 1'b1;
      permit_neg <= 1'b1;
      stop_immediate <= 1'b0;
      stop_decel <= 1'b0;
      stop_target <= {POS_W{1'b0}};
    end else begin
      ot_pos <= beyond_pos;
      ot_neg <= beyond_neg;
      permit_pos <= allow_p;
      permit_neg <= allow_n;
      stop_immediate <= (need_stop || lim_stop) &&
        (ot_action == `PLW_OT_IMMEDIATE);
      stop_decel <= (need_stop || lim_stop) &&
        (ot_action == `PLW_OT_DECEL);
      stop_target <= step_dir ? pos_limit : neg_limit;
    end
  end

  // ****************************************
  // command position and wrap
  // ****************************************
  reg [POS_W-1:0] next_cmd_position;
  reg [ROT_W-1:0] next_multi_rot;
  wire [POS_W-1:0] pos_inc;
  wire [POS_W-1:0] pos_dec;
  wire step_ok_p;
  wire step_ok_n;

  assign pos_inc = cmd_position + {{(POS_W-1){1'b0}}, 1'b1};
  assign pos_dec = cmd_position - {{(POS_W-1){1'b0}}, 1'b1};
  assign step_ok_p = step_pulse && step_dir && allow_p;
  assign step_ok_n = step_pulse && !step_dir && allow_n;

  always @* begin
    next_cmd_position = cmd_position;
    next_multi_rot = multi_rot;
    if (set_origin) begin
      next_cmd_position = {POS_W{1'b0}};
      next_multi_rot = {ROT_W{1'b0}};
    end else if (step_ok_p) begin
      if (wrap_en && (pos_inc >= wrap_range)) begin
        next_cmd_position = {POS_W{1'b0}};
        next_multi_rot = {ROT_W{1'b0}};
      end else begin
        next_cmd_position = pos_inc;
        if (pos_inc == {1'b1, {(POS_W-1){1'b0}}}) begin
          next_multi_rot = multi_rot + {{(ROT_W-1){1'b0}}, 1'b1};
        end
      end
    end else if (step_ok_n) begin
      if (wrap_en && ((cmd_position == {POS_W{1'b0}}) || (cmd_position >= wrap_range))) begin
        next_cmd_position = wrap_range - {{(POS_W-1){1'b0}}, 1'b1};
        next_multi_rot = {ROT_W{1'b0}};
      end else begin
        next_cmd_position = pos_dec;
        if (cmd_position == {1'b1, {(POS_W-1){1'b0}}}) begin
          next_multi_rot = multi_rot - {{(ROT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  always @(posedge clk) begin
    if (!nrst) begin
      cmd_position <= {POS_W{1'b0}};
      multi_rot <= {ROT_W{1'b0}};
    end else begin
      cmd_position <= next_cmd_position;
      multi_rot <= next_multi_rot;
    end
  end

  // ****************************************
  // homing incomplete alarm
  // ****************************************
  wire start_any;
  wire start_rise;
  assign start_any = start_input || sequential_start_input || (direct_select_inputs != 6'h00);
  assign start_rise = start_any && !start_prev;

  always @(posedge clk) begin
    if (!nrst) begin
      start_prev <= 1'b0;
      home_alarm <= 1'b0;
      positioning_refused <= 1'b0;
    end else begin
      start_prev <= start_any;
      positioning_refused <= home_alarm_en && !origin_set;
      if (home_alarm_en && !origin_set && start_rise) begin
        home_alarm <= 1'b1;
      end else if (alarm_reset_input) begin
        home_alarm <= 1'b0;
      end
    end
  end

  // ****************************************
  // wrap setting validation
  // ****************************************
  wire [25:0] gb_k;
  wire [21:0] ga_k;
  wire [45:0] rng_ga;
  wire [25:0] rem1;
  wire [45:0] rem2;
  wire cond_ok;
  assign gb_k = {{(26-GEAR_W){1'b0}}, gear_b} * {16'h0000, `PLW_GEAR_B_MUL};
  assign ga_k = {{(22-GEAR_W){1'b0}}, gear_a} * {16'h0000, `PLW_GEAR_A_MUL};
  assign rng_ga = {{(46-POS_W){1'b0}}, wrap_range} * {24'h000000, ga_k};
  assign rem1 = (ga_k == 22'h000000) ? 26'h0000001 : (gb_k % {4'h0, ga_k});
  assign rem2 = (gb_k == 26'h0000000) ? 46'h000000000001 : (rng_ga % {20'h00000, gb_k});
  assign cond_ok = (rem1 == 26'h0000000) && (rem2 == 46'h000000000000);

  always @(posedge clk) begin
    if (!nrst) begin
      wrap_warning <= 1'b0;
      wrap_error_alarm <= 1'b0;
    end else begin
      wrap_warning <= wrap_en && !cond_ok;
      if (wrap_warning && (power_on_event || config_execute)) begin
        wrap_error_alarm <= 1'b1;
      end else if (alarm_reset_input) begin
        wrap_error_alarm <= 1'b0;
      end
    end
  end

endmodule // plw_limit_wrap

// >>> plw_limit_wrap_sva.sv
// assertion checker for the limit and wrap manager
`timescale 1ns/1ps
module plw_chk (
  input wire clk,
  input wire nrst,
  input wire homing_done,
  input wire origin_preset_input,
  input wire step_pulse,
  input wire step_dir,
  input wire moving,
  input wire alarm_reset_input,
  input wire [1:0] limit_sensor_inputs,
  input wire [23:0] cmd_position,
  input wire [15:0] multi_rot,
  input wire origin_set,
  input wire permit_pos,
  input wire stop_immediate,
  input wire stop_decel,
  input wire home_alarm,
  input wire wrap_error_alarm
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire org = homing_done | origin_preset_input;
  a_origin_sets: assert property (org |=> origin_set && cmd_position == 24'h0
    && multi_rot == 16'h0) else $error("origin not set");
  a_free_step: assert property (step_pulse && step_dir && !org && !origin_set
    && limit_sensor_inputs == 2'h0 |=> cmd_position == $past(cmd_position) + 24'h1
    || cmd_position == 24'h0) else $error("step up lost");
  a_sensor_block: assert property (step_pulse && step_dir && limit_sensor_inputs[1]
    && !org |=> $stable(cmd_position)) else $error("step into sensor");
  a_idle_hold: assert property (!step_pulse && !org |=> $stable(cmd_position))
    else $error("position moved idle");
  a_permit_sensor: assert property (limit_sensor_inputs[1] |=> !permit_pos)
    else $error("positive permit kept");
  a_stop_single: assert property (!(stop_immediate && stop_decel))
    else $error("two stop kinds");
  a_stop_moving: assert property ($rose(stop_immediate) || $rose(stop_decel)
    |-> $past(moving)) else $error("stop while idle");
  a_home_sticky: assert property (home_alarm && !alarm_reset_input |=> home_alarm)
    else $error("home alarm dropped");
  a_home_cause: assert property ($rose(home_alarm) |-> !$past(origin_set))
    else $error("home alarm with origin");
  a_wrap_sticky: assert property (wrap_error_alarm && !alarm_reset_input
    |=> wrap_error_alarm) else $error("wrap alarm dropped");
endmodule // plw_chk
bind plw_limit_wrap plw_chk plw_chk_inst (.clk(clk), .nrst(nrst), .homing_done(homing_done),
  .origin_preset_input(origin_preset_input), .step_pulse(step_pulse), .step_dir(step_dir),
  .moving(moving), .alarm_reset_input(alarm_reset_input),
  .limit_sensor_inputs(limit_sensor_inputs), .cmd_position(cmd_position),
  .multi_rot(multi_rot), .origin_set(origin_set), .permit_pos(permit_pos),
  .stop_immediate(stop_immediate), .stop_decel(stop_decel), .home_alarm(home_alarm),
  .wrap_error_alarm(wrap_error_alarm));

// >>> plw_profile.sv
// profile generator model issuing one step per request
`timescale 1ns/1ps
module plw_profile (
  input wire clk,
  input wire nrst,
  input wire req,
  input wire dir,
  output reg step_pulse,
  output reg step_dir,
  output reg moving
);
  always @(posedge clk) begin
    step_pulse <= nrst & req;
    step_dir <= dir;
    moving <= nrst & req;
  end
endmodule // plw_profile

// >>> plw_limit_wrap_test.sv
// self-checking bench for the limit and wrap manager
`timescale 1ns/1ps
`include "plw_regs.vh"
module plw_limit_wrap_test;
  logic clk = 0, nrst = 0, cfg_load = 0, req = 0, dir = 0, power_on_event = 0;
  logic config_execute = 0, homing_done = 0, origin_preset_input = 0, alarm_reset_input = 0;
  logic cfg_soft_ot_enable = `PLW_SOFT_OT_RST, cfg_ot_action = `PLW_OT_ACTION_RST;
  logic cfg_home_alarm_enable = `PLW_HOME_ALM_RST, cfg_wrap_enable = `PLW_WRAP_EN_RST;
  logic [23:0] cfg_pos_limit = `PLW_POS_LIMIT_RST, cfg_neg_limit = `PLW_NEG_LIMIT_RST;
  logic [23:0] cfg_wrap_range = `PLW_WRAP_RANGE_RST;
  logic [15:0] cfg_gear_a = `PLW_GEAR_RST, cfg_gear_b = `PLW_GEAR_RST;
  logic cfg_abs_backup_enable = `PLW_ABS_BACKUP_RST, abs_error_alarm = 0, abs_error_clear_input = 0;
  logic [7:0] src = 0;
  logic [1:0] limit_sensor_inputs = 0, move_type = 0;
  wire [23:0] cmd_position, stop_target;
  wire [15:0] multi_rot;
  wire origin_set, ot_pos, ot_neg, permit_pos, permit_neg, stop_immediate, stop_decel;
  wire home_alarm, positioning_refused, wrap_warning, wrap_error_alarm, step_pulse, step_dir;
  wire moving;
  integer n_mismatch = 0, cmp_count = 0, mpos = 0, i;
  bit org = 0;
  plw_profile plw_profile_inst (.clk(clk), .nrst(nrst), .req(req), .dir(dir),
    .step_pulse(step_pulse), .step_dir(step_dir), .moving(moving));
  plw_limit_wrap plw_limit_wrap_inst (.clk(clk), .nrst(nrst), .cfg_load(cfg_load),
    .cfg_soft_ot_enable(cfg_soft_ot_enable), .cfg_ot_action(cfg_ot_action),
    .cfg_pos_limit(cfg_pos_limit), .cfg_neg_limit(cfg_neg_limit),
    .cfg_home_alarm_enable(cfg_home_alarm_enable), .cfg_wrap_enable(cfg_wrap_enable),
    .cfg_wrap_range(cfg_wrap_range), .cfg_gear_a(cfg_gear_a), .cfg_gear_b(cfg_gear_b),
    .cfg_abs_backup_enable(cfg_abs_backup_enable), .power_on_event(power_on_event),
    .config_execute(config_execute), .homing_done(homing_done),
    .origin_preset_input(origin_preset_input), .abs_error_alarm(abs_error_alarm),
    .abs_error_clear_input(abs_error_clear_input), .alarm_reset_input(alarm_reset_input),
    .start_input(src[7]), .sequential_start_input(src[6]), .direct_select_inputs(src[5:0]),
    .limit_sensor_inputs(limit_sensor_inputs), .moving(moving), .move_type(move_type),
    .step_pulse(step_pulse), .step_dir(step_dir), .cmd_position(cmd_position),
    .multi_rot(multi_rot), .origin_set(origin_set), .ot_pos(ot_pos), .ot_neg(ot_neg),
    .permit_pos(permit_pos), .permit_neg(permit_neg), .stop_immediate(stop_immediate),
    .stop_decel(stop_decel), .stop_target(stop_target), .home_alarm(home_alarm),
    .positioning_refused(positioning_refused), .wrap_warning(wrap_warning),
    .wrap_error_alarm(wrap_error_alarm));
  initial forever #50 clk = ~clk;
  task tick;
    @(posedge clk) #10;
  endtask
  task chk(input logic [23:0] s, input logic [23:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task results;
    if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function bit warn();
    int a, b;
    a = cfg_gear_a * 50;
    b = cfg_gear_b * 1000;
    warn = cfg_wrap_enable && (a == 0 || b % a != 0 || (cfg_wrap_range * a) % b != 0);
  endfunction
  task cfg;
    cfg_load = 1;
    repeat (3) tick;
    cfg_load = 0;
    tick;
    chk(wrap_warning, warn());
  endtask
  task step(input bit d);
    bit ca, st, ok;
    ca = cfg_soft_ot_enable && org && !cfg_wrap_enable;
    st = ca && (d ? mpos >= $signed(cfg_pos_limit) : mpos <= $signed(cfg_neg_limit));
    ok = !st && !limit_sensor_inputs[d] && !(move_type == 0 && limit_sensor_inputs != 0);
    req = 1;
    dir = d;
    tick;
    req = 0;
    tick;
    if (ok && cfg_wrap_enable)
      mpos = d ? (mpos + 1 >= cfg_wrap_range ? 0 : mpos + 1)
        : (mpos == 0 || mpos >= cfg_wrap_range ? cfg_wrap_range - 1 : mpos - 1);
    else if (ok) mpos = d ? mpos + 1 : mpos - 1;
    chk(cmd_position, mpos[23:0]);
    chk(stop_immediate, st && !cfg_ot_action);
    chk(stop_decel, st && cfg_ot_action);
    if (st && cfg_ot_action) chk(stop_target, d ? cfg_pos_limit : cfg_neg_limit);
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    results;
  end
  initial begin
    void'($urandom(32'h4C9D));
    repeat (10) tick;
    nrst = 1;
    chk({permit_pos, permit_neg, origin_set}, 24'h6);
    src = 8'h80;
    repeat (3) tick;
    src = 0;
    chk(home_alarm, 0);
    cfg_pos_limit = 24'h3;
    cfg_neg_limit = 24'hFFFFFD;
    cfg;
    for (i = 0; i < 16; i++) begin
      move_type = 1 + $urandom % 3;
      step($urandom % 2);
    end
    origin_preset_input = 1;
    tick;
    origin_preset_input = 0;
    mpos = 0;
    org = 1;
    chk(origin_set, 1);
    chk(cmd_position, 0);
    for (i = 0; i < 4; i++) step(1);
    cfg_ot_action = `PLW_OT_DECEL;
    cfg;
    step(1);
    step(0);
    limit_sensor_inputs = 2'h2;
    move_type = `PLW_MT_POSITION;
    step(0);
    move_type = `PLW_MT_CONTINUOUS;
    step(0);
    step(1);
    chk(permit_pos, 0);
    limit_sensor_inputs = 0;
    cfg_pos_limit = 24'hFFFFFF;
    req = 1;
    dir = 0;
    tick;
    req = 0;
    cfg_load = 1;
    tick;
    cfg_load = 0;
    mpos = mpos - 1;
    chk(cmd_position, mpos[23:0]);
    chk({stop_immediate, stop_decel}, 24'h1);
    tick;
    chk({ot_pos, ot_neg, permit_pos, permit_neg}, 24'h9);
    cfg_home_alarm_enable = 1;
    cfg;
    power_on_event = 1;
    tick;
    power_on_event = 0;
    tick;
    org = 0;
    chk(origin_set, 0);
    chk(positioning_refused, 1);
    for (i = 0; i < 3; i++) begin
      src = i < 2 ? 8'h80 >> i : 8'h01 << ($urandom % 6);
      repeat (3) tick;
      src = 0;
      chk(home_alarm, 1);
      alarm_reset_input = 1;
      tick;
      alarm_reset_input = 0;
      tick;
      chk(home_alarm, 0);
    end
    homing_done = 1;
    tick;
    homing_done = 0;
    mpos = 0;
    tick;
    org = 1;
    chk({origin_set, positioning_refused}, 24'h2);
    cfg_wrap_enable = 1;
    cfg_wrap_range = 24'h14;
    cfg_pos_limit = 24'h1;
    cfg_abs_backup_enable = 1;
    cfg;
    origin_preset_input = 1;
    tick;
    origin_preset_input = 0;
    power_on_event = 1;
    tick;
    power_on_event = 0;
    abs_error_alarm = 1;
    chk(origin_set, 1);
    chk(wrap_error_alarm, 0);
    tick;
    abs_error_alarm = 0;
    org = 0;
    chk(origin_set, 0);
    abs_error_clear_input = 1;
    tick;
    abs_error_clear_input = 0;
    origin_preset_input = 1;
    tick;
    origin_preset_input = 0;
    org = 1;
    mpos = 0;
    chk(origin_set, 1);
    cfg_wrap_range = 24'h3;
    cfg;
    origin_preset_input = 1;
    tick;
    origin_preset_input = 0;
    for (i = 0; i < 6; i++) step(i < 4);
    chk(multi_rot, 0);
    config_execute = 1;
    tick;
    config_execute = 0;
    tick;
    chk(wrap_error_alarm, 1);
    results;
  end
endmodule // plw_limit_wrap_test
